// ---- hw/event_fragment_input_frontend.sv ----
// Function
// - Half-full input FIFO asserts link flow-off
// - Keep 512 spare words after flow-off
// - Input hold stops reads into pipeline
// - Link data width select held at 00
// - Return lines driven constant 0000
// - State machine performs link reset sequence
// - Words pass clocked pipeline before memory
// - Contiguous wrapping buffer addresses
// - Stop storing beyond programmable event size
// - Oversize event raises enabled summary fault
// - Link error interrupts, address captured readable
// - Masked 33-bit start/end pattern comparators
// - Double start or end raises framing error
// - Summary FIFO 32 pages, eight words
// - DMA request while data, read select
// - One page per event, FIFO order
// - Header counter restarts at block start
// - Three header selections copy matching words
// - Copy chosen words before block end
// - Summary full/empty raise enabled fault
// - Summary empty always on flag output
// - Pattern/mask 33 bits, control bit 0
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module event_fragment_input_frontend
	import event_fragment_input_frontend_pkg::*;
#(
	parameter int IN_AW   = 10,
	parameter int ADDR_W  = 18,
	parameter int PAGE_AW = 5
) (
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              link_clk_i,
	input  wire logic [31:0]       link_data_i,
	input  wire logic              link_ctrl_n_i,
	input  wire logic              link_wen_n_i,
	input  wire logic              link_derr_n_i,
	input  wire logic              link_down_n_i,
	output logic                   link_xoff_n_o,
	output logic                   link_reset_n_o,
	output logic [1:0]             link_dw_o,
	output logic [3:0]             link_return_o,
	output logic                   link_test_n_o,
	input  wire logic              input_hold_n_i,
	output logic                   mem_we_o,
	output logic [ADDR_W-1:0]      mem_addr_o,
	output logic [31:0]            mem_data_o,
	input  wire logic              fifo_read_select_i,
	output logic                   dma_request_in_o,
	output logic [31:0]            sum_data_o,
	output logic                   sum_empty_flag_o,
	output logic                   summary_fault_interrupt_n_o,
	output logic                   link_error_interrupt_n_o,
	output logic                   framing_error_interrupt_n_o,
	input  wire logic [4:0]        reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic [31:0]            reg_rdata_o
);

	localparam int IN_DEPTH = 1 << IN_AW;
	localparam int PAGES    = 1 << PAGE_AW;
	localparam logic [IN_AW:0] HALF_LVL = (IN_AW+1)'(IN_DEPTH / 2);

	// ==========================================================
	// Link input synchronisers (three stages, last two agree)
	logic [36:0] lk_s1_q, lk_s2_q, lk_s3_q;
	logic        lclk_st_q;
	logic        down_st_q;

	always_ff @(posedge ref_clk_i) begin
		lk_s1_q <= {link_clk_i, link_down_n_i, link_derr_n_i, link_wen_n_i,
		            link_ctrl_n_i, link_data_i};
		lk_s2_q <= lk_s1_q;
		lk_s3_q <= lk_s2_q;
	end

	wire lclk_agree = lk_s2_q[36] == lk_s3_q[36];
	wire lclk_rise  = lclk_agree && lk_s3_q[36] && !lclk_st_q;
	wire down_agree = lk_s2_q[35] == lk_s3_q[35];

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			lclk_st_q <= 1'b0;
			down_st_q <= 1'b0;
		end else begin
			if (lclk_agree)
				lclk_st_q <= lk_s3_q[36];
			if (down_agree)
				down_st_q <= lk_s3_q[35];
		end
	end

	// ==========================================================
	// Link reset sequencer
	typedef enum logic [1:0] {LR_ASSERT, LR_WAIT_UP, LR_UP} lreset_e;
	lreset_e     lr_q;
	logic [4:0]  lr_cnt_q;
	logic        lreset_req;
	wire         lr_hold_done = lr_cnt_q == 5'(LRESET_HOLD - 1);

	// Reset stays low for a minimum hold, then until the link reports up
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			lr_q     <= LR_ASSERT;
			lr_cnt_q <= '0;
		end else begin
			case (lr_q)
				LR_ASSERT: begin
					lr_cnt_q <= lr_cnt_q + 5'h01;
					if (lr_hold_done)
						lr_q <= LR_WAIT_UP;
				end
				LR_WAIT_UP: begin
					if (down_st_q)
						lr_q <= LR_UP;
				end
				LR_UP: begin
					lr_cnt_q <= '0;
					if (lreset_req)
						lr_q <= LR_ASSERT;
				end
				default: lr_q <= LR_ASSERT;
			endcase
		end
	end

	wire link_up = lr_q == LR_UP;

	// ==========================================================
	// Input FIFO: data, control bit and error bit per word
	logic [33:0]     in_mem [IN_DEPTH];
	logic [IN_AW:0]  in_wp_q, in_rp_q;
	wire [IN_AW:0]   in_cnt   = in_wp_q - in_rp_q;
	wire             in_full  = in_cnt == (IN_AW+1)'(IN_DEPTH);
	wire             in_empty = in_cnt == '0;
	wire             in_push  = lclk_rise && !lk_s3_q[33] && !in_full && link_up;
	wire             in_pop   = !in_empty && input_hold_n_i;

	always_ff @(posedge ref_clk_i) begin
		if (in_push)
			in_mem[in_wp_q[IN_AW-1:0]] <= {!lk_s3_q[34], !lk_s3_q[32], lk_s3_q[31:0]};
	end

	// Link reset flushes the FIFO along with the link
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i || !link_up) begin
			in_wp_q <= '0;
			in_rp_q <= '0;
		end else begin
			if (in_push)
				in_wp_q <= in_wp_q + 1'b1;
			if (in_pop)
				in_rp_q <= in_rp_q + 1'b1;
		end
	end

	// ==========================================================
	// Pipeline: stage 1 reads and compares, stage 2 stores
	logic [31:0] bob_pat_q, bob_mask_q, eob_pat_q, eob_mask_q;
	logic        bob_cpat_q, bob_cmask_q, eob_cpat_q, eob_cmask_q;
	logic [33:0] p1_q, p2_q;
	logic        p1_vld_q, p2_vld_q, p2_bob_q, p2_eob_q;

	// Masked compare over 32 data bits plus control bit
	wire bob_hit = ((p1_q[31:0] ^ bob_pat_q) & bob_mask_q) == '0 &&
	               ((p1_q[32] ^ bob_cpat_q) & bob_cmask_q) == 1'b0;
	wire eob_hit = ((p1_q[31:0] ^ eob_pat_q) & eob_mask_q) == '0 &&
	               ((p1_q[32] ^ eob_cpat_q) & eob_cmask_q) == 1'b0;

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			p1_vld_q <= 1'b0;
			p2_vld_q <= 1'b0;
			p1_q     <= '0;
			p2_q     <= '0;
			p2_bob_q <= 1'b0;
			p2_eob_q <= 1'b0;
		end else begin
			p1_vld_q <= in_pop;
			p1_q     <= in_mem[in_rp_q[IN_AW-1:0]];
			p2_vld_q <= p1_vld_q;
			p2_q     <= p1_q;
			p2_bob_q <= p1_vld_q && bob_hit;
			p2_eob_q <= p1_vld_q && eob_hit && !bob_hit;
		end
	end

	// ==========================================================
	// Event tracking, size limit, address generation
	logic [17:0]       size_limit_q, evt_cnt_q;
	logic [ADDR_W-1:0] wa_q, lerr_addr_q, frame_addr_q;
	logic              in_block_q, ovfl_q, lerr_q, lerr2_q, frame_q;
	logic [4:0]        hdr_cnt_q;
	logic [31:0]       prev1_q, prev2_q;
	logic              clr_ovfl, clr_lerr, clr_frame;

	wire too_big  = in_block_q && !p2_bob_q && evt_cnt_q >= size_limit_q;
	wire store    = p2_vld_q && !too_big;
	wire is_data  = p2_vld_q && !p2_bob_q && !p2_eob_q;
	wire dbl_mark = (p2_bob_q && in_block_q) || (p2_eob_q && !in_block_q);
	wire lerr_ev  = store && p2_q[33];

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			mem_we_o   <= 1'b0;
			mem_addr_o <= '0;
			mem_data_o <= '0;
			wa_q       <= '0;
		end else begin
			mem_we_o <= store;
			if (store) begin
				mem_addr_o <= wa_q;
				mem_data_o <= p2_q[31:0];
				wa_q       <= wa_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			in_block_q <= 1'b0;
			evt_cnt_q  <= '0;
			hdr_cnt_q  <= '0;
			prev1_q    <= '0;
			prev2_q    <= '0;
		end else if (p2_vld_q) begin
			if (p2_bob_q) begin
				in_block_q <= 1'b1;
				evt_cnt_q  <= 18'h00001;
				hdr_cnt_q  <= '0;
			end else begin
				if (p2_eob_q)
					in_block_q <= 1'b0;
				if (evt_cnt_q != '1)
					evt_cnt_q <= evt_cnt_q + 18'h00001;
				if (is_data && hdr_cnt_q != '1)
					hdr_cnt_q <= hdr_cnt_q + 5'h01;
				if (is_data) begin
					prev1_q <= p2_q[31:0];
					prev2_q <= prev1_q;
				end
			end
		end
	end

	// Sticky error flags; a new event wins over a software clear
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			ovfl_q       <= 1'b0;
			lerr_q       <= 1'b0;
			lerr2_q      <= 1'b0;
			frame_q      <= 1'b0;
			lerr_addr_q  <= '0;
			frame_addr_q <= '0;
		end else begin
			ovfl_q  <= (ovfl_q && !clr_ovfl) || (p2_vld_q && too_big);
			lerr_q  <= (lerr_q && !clr_lerr) || lerr_ev;
			lerr2_q <= (lerr2_q && !clr_lerr) || (lerr_ev && lerr_q);
			frame_q <= (frame_q && !clr_frame) || dbl_mark;
			if (lerr_ev)
				lerr_addr_q <= wa_q;
			if (dbl_mark)
				frame_addr_q <= wa_q;
		end
	end

	// ==========================================================
	// Summary FIFO: pages assembled in a staging area, then committed
	logic [31:0]      stg_q [PAGE_WORDS];
	logic [255:0]     sum_mem [PAGES];
	logic [PAGE_AW:0] sp_wp_q, sp_rp_q;
	logic [2:0]       sw_idx_q;
	logic [5:0]       hdr_sel_q [3];
	logic [1:0]       tail_sel_q;
	logic             sum_rd_d;

	wire [PAGE_AW:0] sp_cnt  = sp_wp_q - sp_rp_q;
	wire             s_full  = sp_cnt == (PAGE_AW+1)'(PAGES);
	wire             s_empty = sp_cnt == '0;
	wire             commit  = p2_eob_q && in_block_q && !s_full;
	wire [255:0]     stg_flat = {stg_q[7], stg_q[6], stg_q[5], stg_q[4],
	                             stg_q[3], stg_q[2], stg_q[1], stg_q[0]};

	logic [2:0] hdr_pick;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_hdr
			// Header word copied when its position matches an enabled pick
			assign hdr_pick[g] = is_data && in_block_q && hdr_sel_q[g][SEL_ENA_BIT] &&
			                     hdr_sel_q[g][4:0] == hdr_cnt_q;
		end
	endgenerate

	// One process owns the whole staging area, so it has a single driver
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			stg_q <= '{default: '0};
		end else if (p2_bob_q) begin
			stg_q            <= '{default: '0};
			stg_q[SLOT_ADDR] <= 32'(wa_q);
		end else begin
			for (int i = 0; i < 3; i++)
				if (hdr_pick[i])
					stg_q[SLOT_HDR0+i] <= p2_q[31:0];
			if (p2_eob_q && tail_sel_q[0])
				stg_q[SLOT_TAIL0] <= prev1_q;
			if (p2_eob_q && tail_sel_q[1])
				stg_q[SLOT_TAIL1] <= prev2_q;
		end
	end

	// Tail words land in staging one cycle after the end mark
	logic commit_q;
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i)
			commit_q <= 1'b0;
		else
			commit_q <= commit;
		if (commit_q)
			sum_mem[sp_wp_q[PAGE_AW-1:0]] <= stg_flat;
	end

	assign sum_rd_d = fifo_read_select_i && !s_empty;

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			sp_wp_q    <= '0;
			sp_rp_q    <= '0;
			sw_idx_q   <= '0;
			sum_data_o <= '0;
		end else begin
			if (commit_q)
				sp_wp_q <= sp_wp_q + 1'b1;
			sum_data_o <= '0;
			if (sum_rd_d) begin
				sum_data_o <= sum_mem[sp_rp_q[PAGE_AW-1:0]][sw_idx_q*32 +: 32];
				sw_idx_q   <= sw_idx_q + 3'h1;
				if (sw_idx_q == 3'h7)
					sp_rp_q <= sp_rp_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// Register port
	logic [2:0] fault_ena_q;
	wire        wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL_STAT;
	assign clr_ovfl   = wr_ctrl && reg_wdata_i[ST_OVFL_BIT];
	assign clr_lerr   = (wr_ctrl && reg_wdata_i[ST_LERR_BIT]) ||
	                    (reg_wr_i && reg_addr_i == OFS_LERR_ADDR);
	assign clr_frame  = (wr_ctrl && reg_wdata_i[ST_FRAME_BIT]) ||
	                    (reg_wr_i && reg_addr_i == OFS_FRAME_ADDR);
	assign lreset_req = wr_ctrl && reg_wdata_i[CT_LRESET_BIT];

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			bob_pat_q    <= '0;
			bob_mask_q   <= '0;
			eob_pat_q    <= '0;
			eob_mask_q   <= '0;
			bob_cpat_q   <= 1'b0;
			bob_cmask_q  <= 1'b0;
			eob_cpat_q   <= 1'b0;
			eob_cmask_q  <= 1'b0;
			hdr_sel_q    <= '{default: '0};
			tail_sel_q   <= '0;
			size_limit_q <= SIZE_LIMIT_RST;
			fault_ena_q  <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_BOB_PAT:    bob_pat_q    <= reg_wdata_i;
				OFS_BOB_CPAT:   bob_cpat_q   <= reg_wdata_i[0];
				OFS_BOB_MASK:   bob_mask_q   <= reg_wdata_i;
				OFS_BOB_CMASK:  bob_cmask_q  <= reg_wdata_i[0];
				OFS_EOB_PAT:    eob_pat_q    <= reg_wdata_i;
				OFS_EOB_CPAT:   eob_cpat_q   <= reg_wdata_i[0];
				OFS_EOB_MASK:   eob_mask_q   <= reg_wdata_i;
				OFS_EOB_CMASK:  eob_cmask_q  <= reg_wdata_i[0];
				OFS_HDR_SEL0:   hdr_sel_q[0] <= reg_wdata_i[5:0];
				OFS_HDR_SEL1:   hdr_sel_q[1] <= reg_wdata_i[5:0];
				OFS_HDR_SEL2:   hdr_sel_q[2] <= reg_wdata_i[5:0];
				OFS_TAIL_SEL0:  tail_sel_q[0] <= reg_wdata_i[0];
				OFS_TAIL_SEL1:  tail_sel_q[1] <= reg_wdata_i[0];
				OFS_SIZE_LIMIT: size_limit_q <= reg_wdata_i[17:0];
				OFS_FAULT_ENA:  fault_ena_q  <= reg_wdata_i[2:0];
				default: ;
			endcase
		end
	end

	logic [31:0] rd_mux;
	wire  [7:0]  status = {link_up, !link_xoff_n_o, s_full, s_empty,
	                       lerr2_q, frame_q, lerr_q, ovfl_q};

	always_comb begin
		case (reg_addr_i)
			OFS_BOB_PAT:    rd_mux = bob_pat_q;
			OFS_BOB_CPAT:   rd_mux = {31'h0, bob_cpat_q};
			OFS_BOB_MASK:   rd_mux = bob_mask_q;
			OFS_BOB_CMASK:  rd_mux = {31'h0, bob_cmask_q};
			OFS_EOB_PAT:    rd_mux = eob_pat_q;
			OFS_EOB_CPAT:   rd_mux = {31'h0, eob_cpat_q};
			OFS_EOB_MASK:   rd_mux = eob_mask_q;
			OFS_EOB_CMASK:  rd_mux = {31'h0, eob_cmask_q};
			OFS_HDR_SEL0:   rd_mux = {26'h0, hdr_sel_q[0]};
			OFS_HDR_SEL1:   rd_mux = {26'h0, hdr_sel_q[1]};
			OFS_HDR_SEL2:   rd_mux = {26'h0, hdr_sel_q[2]};
			OFS_TAIL_SEL0:  rd_mux = {31'h0, tail_sel_q[0]};
			OFS_TAIL_SEL1:  rd_mux = {31'h0, tail_sel_q[1]};
			OFS_SIZE_LIMIT: rd_mux = {14'h0, size_limit_q};
			OFS_FAULT_ENA:  rd_mux = {29'h0, fault_ena_q};
			OFS_LERR_ADDR:  rd_mux = 32'(lerr_addr_q);
			OFS_FRAME_ADDR: rd_mux = 32'(frame_addr_q);
			OFS_CTRL_STAT:  rd_mux = {24'h0, status};
			default:        rd_mux = 32'h0;
		endcase
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			reg_rdata_o                 <= '0;
			link_xoff_n_o               <= 1'b1;
			link_reset_n_o              <= 1'b0;
			link_dw_o                   <= LINK_DW_32;
			link_return_o               <= LINK_RET_IDLE;
			link_test_n_o               <= 1'b1;
			dma_request_in_o            <= 1'b0;
			sum_empty_flag_o            <= 1'b1;
			summary_fault_interrupt_n_o <= 1'b1;
			link_error_interrupt_n_o    <= 1'b1;
			framing_error_interrupt_n_o <= 1'b1;
		end else begin
			reg_rdata_o    <= reg_rd_i ? rd_mux : 32'h0;
			// Flow-off at half full leaves the upper half as spare room
			link_xoff_n_o  <= in_cnt < HALF_LVL;
			link_reset_n_o <= lr_q == LR_UP;
			link_dw_o      <= LINK_DW_32;
			link_return_o  <= LINK_RET_IDLE;
			link_test_n_o  <= 1'b1;
			dma_request_in_o <= !s_empty &&
			                    !(sum_rd_d && sp_cnt == (PAGE_AW+1)'(1) && sw_idx_q == 3'h7);
			sum_empty_flag_o <= s_empty;
			summary_fault_interrupt_n_o <= !((s_empty && fault_ena_q[ENA_EMPTY_BIT]) ||
			                                 (s_full && fault_ena_q[ENA_FULL_BIT]) ||
			                                 (ovfl_q && fault_ena_q[ENA_OVFL_BIT]));
			link_error_interrupt_n_o    <= !lerr_q;
			framing_error_interrupt_n_o <= !frame_q;
		end
	end

	// ==========================================================
	// Assertions
	property p_xoff_half;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		in_cnt >= HALF_LVL |=> !link_xoff_n_o;
	endproperty
	a_xoff_half: assert property (p_xoff_half) else $error("no flow-off at half full");

	property p_spare_room;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		link_xoff_n_o |-> in_cnt <= (IN_AW+1)'(IN_DEPTH / 2);
	endproperty
	a_spare_room: assert property (p_spare_room) else $error("spare room lost");

	property p_hold_stops;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		!input_hold_n_i |=> !p1_vld_q ##1 !p2_vld_q;
	endproperty
	a_hold_stops: assert property (p_hold_stops) else $error("read during hold");

	property p_fixed_lines;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		$past(reset_n_i) |-> link_dw_o == 2'h0 && link_return_o == 4'h0;
	endproperty
	a_fixed_lines: assert property (p_fixed_lines) else $error("fixed link lines moved");

	property p_lreset_release;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(link_reset_n_o) |-> $past(down_st_q, 2);
	endproperty
	a_lreset_release: assert property (p_lreset_release) else $error("early link reset release");

	property p_contig_addr;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		mem_we_o ##1 mem_we_o |-> mem_addr_o == $past(mem_addr_o) + 1'b1;
	endproperty
	a_contig_addr: assert property (p_contig_addr) else $error("address not contiguous");

	property p_size_stop;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		p2_vld_q && too_big |=> !mem_we_o ##1 ovfl_q;
	endproperty
	a_size_stop: assert property (p_size_stop) else $error("oversize word stored");

	property p_lerr_addr;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		lerr_ev |=> lerr_q && lerr_addr_q == mem_addr_o ##1 !link_error_interrupt_n_o;
	endproperty
	a_lerr_addr: assert property (p_lerr_addr) else $error("link error not captured");

	property p_hdr_restart;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		p2_bob_q |=> hdr_cnt_q == 5'h00;
	endproperty
	a_hdr_restart: assert property (p_hdr_restart) else $error("header counter not restarted");

	property p_empty_flag;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_empty |=> sum_empty_flag_o && !dma_request_in_o;
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag or request wrong");

endmodule : event_fragment_input_frontend

// ---- hw/event_fragment_input_frontend_pkg.sv ----
package event_fragment_input_frontend_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [4:0] OFS_BOB_PAT      = 5'h00;
	localparam logic [4:0] OFS_BOB_CPAT     = 5'h01;
	localparam logic [4:0] OFS_BOB_MASK     = 5'h02;
	localparam logic [4:0] OFS_BOB_CMASK    = 5'h03;
	localparam logic [4:0] OFS_EOB_PAT      = 5'h04;
	localparam logic [4:0] OFS_EOB_CPAT     = 5'h05;
	localparam logic [4:0] OFS_EOB_MASK     = 5'h06;
	localparam logic [4:0] OFS_EOB_CMASK    = 5'h07;
	localparam logic [4:0] OFS_HDR_SEL0     = 5'h09;
	localparam logic [4:0] OFS_HDR_SEL1     = 5'h0a;
	localparam logic [4:0] OFS_HDR_SEL2     = 5'h0b;
	localparam logic [4:0] OFS_TAIL_SEL0    = 5'h0c;
	localparam logic [4:0] OFS_TAIL_SEL1    = 5'h0d;
	localparam logic [4:0] OFS_SIZE_LIMIT   = 5'h0e;
	localparam logic [4:0] OFS_FAULT_ENA    = 5'h0f;
	localparam logic [4:0] OFS_LERR_ADDR    = 5'h10;
	localparam logic [4:0] OFS_FRAME_ADDR   = 5'h11;
	localparam logic [4:0] OFS_CTRL_STAT    = 5'h15;

	// ==========================================================
	// Field positions
	localparam int SEL_ENA_BIT    = 5;
	localparam int ENA_EMPTY_BIT  = 0;
	localparam int ENA_FULL_BIT   = 1;
	localparam int ENA_OVFL_BIT   = 2;
	localparam int ST_OVFL_BIT    = 0;
	localparam int ST_LERR_BIT    = 1;
	localparam int ST_FRAME_BIT   = 2;
	localparam int ST_LERR2_BIT   = 3;
	localparam int ST_EMPTY_BIT   = 4;
	localparam int ST_FULL_BIT    = 5;
	localparam int ST_XOFF_BIT    = 6;
	localparam int ST_LINKUP_BIT  = 7;
	localparam int CT_LRESET_BIT  = 8;
	localparam int SLOT_ADDR      = 0;
	localparam int SLOT_HDR0      = 1;
	localparam int SLOT_TAIL0     = 4;
	localparam int SLOT_TAIL1     = 5;
	localparam int PAGE_WORDS     = 8;

	// ==========================================================
	// Reset values and fixed link levels
	localparam logic [17:0] SIZE_LIMIT_RST = 18'h3ffff;
	localparam logic [1:0]  LINK_DW_32     = 2'h0;
	localparam logic [3:0]  LINK_RET_IDLE  = 4'h0;
	localparam int          LRESET_HOLD    = 16;

endpackage : event_fragment_input_frontend_pkg

// ---- verif/event_fragment_input_frontend_tb_top.sv ----
`timescale 1ns/100ps
module event_fragment_input_frontend_tb_top;
	import event_fragment_input_frontend_pkg::*;
	localparam int          ADDR_W  = 18;
	localparam logic [31:0] START_W = 32'hb0b00001;
	localparam logic [31:0] END_W   = 32'he0b00002;
	logic ref_clk_i, reset_n_i, link_clk_i, link_ctrl_n_i, link_wen_n_i, link_derr_n_i;
	logic link_down_n_i, link_xoff_n_o, link_reset_n_o, link_test_n_o, input_hold_n_i;
	logic mem_we_o, fifo_read_select_i, dma_request_in_o, sum_empty_flag_o, reg_wr_i;
	logic summary_fault_interrupt_n_o, link_error_interrupt_n_o, framing_error_interrupt_n_o;
	logic              reg_rd_i, rd_p, sel_p;
	logic [1:0]        link_dw_o;
	logic [3:0]        link_return_o;
	logic [4:0]        reg_addr_i;
	logic [31:0]       link_data_i, mem_data_o, sum_data_o, reg_wdata_i, reg_rdata_o, d [4];
	logic [ADDR_W-1:0] mem_addr_o, last_a, start_a, nxt_a;
	logic [31:0]       mem_q [$], reg_q [$], sum_q [$];
	int                num_errors, compares, n, seed;
	logic [4:0]  cfg_a [14] = '{OFS_BOB_PAT, OFS_BOB_CPAT, OFS_BOB_MASK, OFS_BOB_CMASK,
		OFS_EOB_PAT, OFS_EOB_CPAT, OFS_EOB_MASK, OFS_EOB_CMASK, OFS_HDR_SEL0,
		OFS_HDR_SEL1, OFS_HDR_SEL2, OFS_TAIL_SEL0, OFS_TAIL_SEL1, OFS_FAULT_ENA};
	// Position 3 left disabled so its slot must stay zero
	logic [31:0] cfg_v [14] = '{START_W, 32'h1, 32'hffffffff, 32'h1, END_W, 32'h1,
		32'hffffffff, 32'h1, 32'h20, 32'h22, 32'h03, 32'h1, 32'h1, 32'h4};

	event_fragment_input_frontend #(.ADDR_W(ADDR_W)) i_dut (.*);
	link_source_model i_src (
		.link_clk_o (link_clk_i),
		.data_o     (link_data_i),
		.ctrl_n_o   (link_ctrl_n_i),
		.wen_n_o    (link_wen_n_i),
		.derr_n_o   (link_derr_n_i),
		.down_n_o   (link_down_n_i)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// ==========================================================
	// Checking
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out

	function automatic logic cond(input int k);
		logic [5:0] c;
		c = {mem_q.size() == 0, summary_fault_interrupt_n_o === 1'b0,
			framing_error_interrupt_n_o === 1'b0, link_error_interrupt_n_o === 1'b0,
			dma_request_in_o === 1'b1, link_reset_n_o === 1'b1};
		return c[k];
	endfunction : cond

	task automatic await(input int k);
		for (n = 0; n < 3000 && !cond(k); n++) @(posedge ref_clk_i);
		if (n == 3000) begin
			num_errors++;
			close_out();
		end
	endtask : await

	// ==========================================================
	// Register port
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, v, 1'b1};
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		reg_q.push_back(exp);
		{reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
	endtask : rd

	task automatic put(input logic [31:0] w, input logic c, input logic e, input logic kept);
		if (kept) mem_q.push_back(w);
		i_src.send(w, c, e);
	endtask : put

	// ==========================================================
	// Result watcher
	always @(posedge ref_clk_i) begin
		if (rd_p) chk(reg_rdata_o, reg_q.pop_front());
		if (sel_p) chk(sum_data_o, sum_q.pop_front());
		// Addresses counted by the bench itself, from zero after reset
		if (mem_we_o === 1'b1) begin
			chk(32'(mem_addr_o), 32'(nxt_a));
			chk(mem_data_o, mem_q.pop_front());
			if (mem_data_o === START_W) start_a = nxt_a;
			last_a = nxt_a;
			nxt_a  = nxt_a + 1'b1;
		end
		rd_p <= reg_rd_i;
		sel_p <= fifo_read_select_i;
	end

	initial begin
		repeat (100000) @(posedge ref_clk_i);
		num_errors++;
		close_out();
	end

	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'hbc39527e;
		{reset_n_i, input_hold_n_i, fifo_read_select_i, reg_wr_i, reg_rd_i} = 5'h08;
		{reg_addr_i, reg_wdata_i, rd_p, sel_p, nxt_a, last_a} = '0;
		{num_errors, compares} = '0;
		repeat (20) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		@(posedge ref_clk_i);
		#1;
		chk(32'({link_reset_n_o, link_test_n_o, link_dw_o, link_return_o, sum_empty_flag_o}),
			32'h81);
		await(0);
		foreach (cfg_a[i]) wr(cfg_a[i], cfg_v[i]);
		for (int i = 0; i < 8; i++) rd(cfg_a[i], cfg_v[i]);
		rd(5'h08, 32'h0);
		foreach (d[i]) d[i] = $random(seed);
		put(START_W, 1'b1, 1'b0, 1'b1);
		foreach (d[i]) put(d[i], 1'b0, 1'b0, 1'b1);
		put(END_W, 1'b1, 1'b0, 1'b1);
		await(1);
		chk(32'(sum_empty_flag_o), 32'h0);
		sum_q = {32'(start_a), d[0], d[2], 32'h0, d[3], d[2], 32'h0, 32'h0};
		@(posedge ref_clk_i);
		fifo_read_select_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		fifo_read_select_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk(32'({dma_request_in_o, sum_empty_flag_o, sum_q.size() == 0}), 32'h3);
		// Hold reads off so the input store fills to its flow-off mark
		input_hold_n_i <= 1'b0;
		for (int i = 0; i < 512; i++) put(32'(i), 1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge ref_clk_i);
		chk(32'({link_xoff_n_o, 10'(mem_q.size())}), 32'h200);
		input_hold_n_i <= 1'b1;
		await(5);
		repeat (2) @(posedge ref_clk_i);
		chk(32'(link_xoff_n_o), 32'h1);
		put(32'h1234, 1'b0, 1'b1, 1'b1);
		await(2);
		await(5);
		rd(OFS_LERR_ADDR, 32'(last_a));
		wr(OFS_SIZE_LIMIT, 32'h2);
		put(START_W, 1'b1, 1'b0, 1'b1);
		put(32'h5a5a0001, 1'b0, 1'b0, 1'b1);
		put(32'h5a5a0002, 1'b0, 1'b0, 1'b0);
		put(START_W, 1'b1, 1'b0, 1'b1);
		await(4);
		await(3);
		await(5);
		rd(OFS_FRAME_ADDR, 32'(last_a));
		rd(OFS_CTRL_STAT, 32'h97);
		// Clear every sticky flag and restart the link
		wr(OFS_CTRL_STAT, 32'h107);
		repeat (3) @(posedge ref_clk_i);
		await(0);
		rd(OFS_CTRL_STAT, 32'h90);
		repeat (4) @(posedge ref_clk_i);
		chk(32'({summary_fault_interrupt_n_o, link_error_interrupt_n_o,
			framing_error_interrupt_n_o}), 32'h7);
		close_out();
	end
endmodule : event_fragment_input_frontend_tb_top

// ---- verif/link_source_model.sv ----
`timescale 1ns/100ps
module link_source_model (
	output logic        link_clk_o,
	output logic [31:0] data_o,
	output logic        ctrl_n_o,
	output logic        wen_n_o,
	output logic        derr_n_o,
	output logic        down_n_o
);
	initial begin
		{link_clk_o, data_o, ctrl_n_o, wen_n_o, derr_n_o} = {1'b0, 32'h0, 3'h7};
		down_n_o = 1'b1;
	end
	// ==========================================================
	// One word per pulse; test-mode data never forwarded
	task automatic send(input logic [31:0] w, input logic c, input logic e);
		{data_o, ctrl_n_o, derr_n_o, wen_n_o} = {w, ~c, ~e, 1'b0};
		#32 link_clk_o = 1'b1;
		#32 link_clk_o = 1'b0;
		// Released lines show the inverse, not the stale word
		{data_o, ctrl_n_o, derr_n_o, wen_n_o} = {~w, c, 1'b1, 1'b1};
	endtask : send
endmodule : link_source_model
